// ==== common/eqr_consts.svh ====
// constants for the equalizer and reclocker mode control block
`ifndef EQR_CONSTS_SVH
`define EQR_CONSTS_SVH
`define EQR_NPIN 2
`define EQR_PIN_ROUTE 0
`define EQR_PIN_OUTFN 1
`define EQR_FLOAT_NUM 2
`define EQR_FLOAT_DEN 3
`define EQR_THR_LR_PM 200
`define EQR_THR_RF_PM 500
`define EQR_THR_FH_PM 800
`define EQR_CMP_RST 3'h3
`define EQR_A_ROUTE 7'h01
`define EQR_A_EQ 7'h02
`define EQR_A_MANUAL 7'h03
`define EQR_A_LOWRATE 7'h04
`define EQR_A_OUT 7'h05
`define EQR_A_STATUS 7'h08
`define EQR_A_BOOST 7'h09
`define EQR_A_PRESET0 7'h40
`define EQR_A_PRESET15 7'h4f
`define EQR_B_ROUTE_OVR 7
`define EQR_B_RATE_OVR 6
`define EQR_B_RATE_ETH 4
`define EQR_B_SPLIT 0
`define EQR_B_BYP_OVR 1
`define EQR_B_BYP 2
`define EQR_B_TMODE_OVR 3
`define EQR_B_TMANUAL 4
`define EQR_B_CDR_RST 5
`define EQR_B_OUT_OVR 7
`define EQR_B_FIRST_OUTPUT_CLK 0
`define EQR_B_SECOND_OUTPUT_CLK 1
`define EQR_B_CDR_BYP 2
`define EQR_REG_RST 8'h00
`define EQR_LOWRATE_RST 8'h00
`define EQR_PRESET_RST 8'h00
`define EQR_NPRESET 16
`define EQR_SPI_BITS 16
`define EQR_CLK_NS 40
`define EQR_SETTLE_NS 1000
`define EQR_SETTLE_CYC ((`EQR_SETTLE_NS + `EQR_CLK_NS - 1) / `EQR_CLK_NS)
`endif

// ==== common/eqr_pkg.sv ====
// types shared by the mode control block
`default_nettype none
package eqr_pkg;
  typedef enum logic [1:0] {
    LVL_L = 2'h0,
    LVL_R = 2'h1,
    LVL_F = 2'h2,
    LVL_H = 2'h3
  } eqr_level_t;
  typedef enum logic [2:0] {
    AD_IDLE = 3'h0,
    AD_LOAD = 3'h1,
    AD_SETTLE = 3'h3,
    AD_SCORE = 3'h2,
    AD_DONE = 3'h6
  } eqr_adapt_t;
  typedef struct packed {
    logic sel_trace;
    logic first_output_en;
    logic second_output_en;
    logic rate_video;
  } eqr_route_t;
  typedef struct packed {
    logic cable_eq_pwr;
    logic trace_eq_pwr;
    logic eq_bypass;
    logic cdr_bypass;
    logic splitter_6db;
    logic cable_adapt_en;
    logic [7:0] trace_boost;
    logic sel_trace;
    logic rate_video;
    logic first_output_en;
    logic second_output_en;
    logic first_output_clk;
    logic second_output_clk;
    logic power_save;
    logic cdr_reset;
  } eqr_ctl_t;
endpackage
`default_nettype wire

// ==== hdl/eqr_level_decode.sv ====
// synchroniser and four-level decoder for the strap pins
`timescale 1ns/100ps
`default_nettype none
`include "eqr_consts.svh"
module eqr_level_decode
  import eqr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`EQR_NPIN-1:0][2:0] cmp,
  output wire eqr_level_t [`EQR_NPIN-1:0] lvl
);
  // comparator bits: [0] above low threshold, [1] above mid, [2] above high
  function automatic eqr_level_t decode(input logic [2:0] t);
    case (t)
      3'h0: decode = LVL_L;
      3'h1: decode = LVL_R;
      3'h3: decode = LVL_F;
      3'h7: decode = LVL_H;
      default: decode = LVL_F; // non-thermometer glitch reads as open pin
    endcase
  endfunction

  for (genvar i = 0; i < `EQR_NPIN; i++) begin : g_pin
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    eqr_level_t lvl_ff;
    always_ff @(posedge core_clk) begin
      if (rst) begin
        meta_ff <= `EQR_CMP_RST;
        sync_ff <= `EQR_CMP_RST;
      end else if (ce) begin
        meta_ff <= cmp[i];
        sync_ff <= meta_ff;
      end
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        lvl_ff <= LVL_F;
      end else if (ce) begin
        lvl_ff <= decode(sync_ff);
      end
    end
    assign lvl[i] = lvl_ff;
  end
endmodule
`default_nettype wire

// ==== hdl/eqr_mode_ctrl.sv ====
// mode, routing and equalizer control with serial register port
`timescale 1ns/100ps
`default_nettype none
`include "eqr_consts.svh"
module eqr_mode_ctrl
  import eqr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] route_cmp,
  input wire logic [2:0] outfn_cmp,
  input wire logic cd_cable,
  input wire logic cd_trace,
  input wire logic rate_low,
  input wire logic [7:0] eye_metric,
  input wire logic spi_ss_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe_n,
  output eqr_ctl_t ctl
);
  eqr_level_t [`EQR_NPIN-1:0] strap_lvl;
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic [5:0] dly_ff;
  logic ss_n_s;
  logic sck_s;
  logic mosi_s;
  logic cd_cable_s;
  logic cd_trace_s;
  logic rate_low_s;
  logic sck_rise;
  logic sck_fall;
  logic [4:0] bit_cnt_ff;
  logic [15:0] shift_ff;
  logic [6:0] miso_sh_ff;
  logic miso_ff;
  logic miso_oe_n_ff;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] route_reg_ff;
  logic [7:0] eq_reg_ff;
  logic [7:0] manual_ff;
  logic [7:0] lowrate_ff;
  logic [7:0] out_reg_ff;
  logic [7:0] preset_ff [`EQR_NPRESET];
  eqr_adapt_t ad_st_ff;
  logic [3:0] idx_ff;
  logic [3:0] best_idx_ff;
  logic [7:0] best_score_ff;
  logic [7:0] wait_ff;
  logic cd_prev_ff;
  eqr_level_t route_lvl;
  eqr_route_t rt;
  logic cd_sel;
  logic trace_auto;
  logic adapt_run;
  logic [7:0] adapt_boost;
  eqr_ctl_t nxt_ctl;
  eqr_ctl_t ctl_ff;

  eqr_level_decode u_straps (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .cmp({outfn_cmp, route_cmp}),
    .lvl(strap_lvl)
  );

  // pins from outside the clock domain, two flops before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_ff <= 6'h01;
      sync_ff <= 6'h01;
      dly_ff <= 6'h01;
    end else if (ce) begin
      meta_ff <= {rate_low, cd_trace, cd_cable, spi_mosi, spi_sck, spi_ss_n};
      sync_ff <= meta_ff;
      dly_ff <= sync_ff;
    end
  end
  assign ss_n_s = sync_ff[0];
  assign sck_s = sync_ff[1];
  assign mosi_s = sync_ff[2];
  assign cd_cable_s = sync_ff[3];
  assign cd_trace_s = sync_ff[4];
  assign rate_low_s = sync_ff[5];
  // sck is oversampled, so it must stay well below a quarter of core_clk
  assign sck_rise = !ss_n_s && sck_s && !dly_ff[1];
  assign sck_fall = !ss_n_s && !sck_s && dly_ff[1];

  // frame: read flag, 7-bit address, 8 data bits, msb first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
    end else if (ce) begin
      if (ss_n_s) begin
        bit_cnt_ff <= 5'h00;
      end else if (sck_rise) begin
        shift_ff <= {shift_ff[14:0], mosi_s};
        bit_cnt_ff <= 5'(bit_cnt_ff + 5'h01);
      end
    end
  end
  assign wr_en = sck_rise && bit_cnt_ff == 5'h0f && !shift_ff[14];
  assign wr_addr = shift_ff[13:7];
  assign wr_data = {shift_ff[6:0], mosi_s};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_ff <= 1'b0;
      miso_sh_ff <= 7'h00;
      miso_oe_n_ff <= 1'b1;
    end else if (ce) begin
      if (ss_n_s) begin
        miso_oe_n_ff <= 1'b1;
      end else if (sck_fall && bit_cnt_ff == 5'h08 && shift_ff[7]) begin
        {miso_ff, miso_sh_ff} <= rd_data;
        miso_oe_n_ff <= 1'b0;
      end else if (sck_fall && bit_cnt_ff > 5'h08) begin
        {miso_ff, miso_sh_ff} <= {miso_sh_ff, 1'b0};
      end
    end
  end
  assign spi_miso_o = miso_ff;
  assign spi_miso_oe_n = miso_oe_n_ff;

  // control registers; splitter mode has no strap source at all
  always_ff @(posedge core_clk) begin
    if (rst) begin
      route_reg_ff <= `EQR_REG_RST;
      eq_reg_ff <= `EQR_REG_RST;
      manual_ff <= `EQR_REG_RST;
      lowrate_ff <= `EQR_LOWRATE_RST;
      out_reg_ff <= `EQR_REG_RST;
    end else if (ce && wr_en) begin
      case (wr_addr)
        `EQR_A_ROUTE: route_reg_ff <= wr_data;
        `EQR_A_EQ: eq_reg_ff <= wr_data;
        `EQR_A_MANUAL: manual_ff <= wr_data;
        `EQR_A_LOWRATE: lowrate_ff <= wr_data;
        `EQR_A_OUT: out_reg_ff <= wr_data;
        default: ;
      endcase
    end
  end

  for (genvar p = 0; p < `EQR_NPRESET; p++) begin : g_preset
    always_ff @(posedge core_clk) begin
      if (rst) begin
        preset_ff[p] <= `EQR_PRESET_RST;
      end else if (ce && wr_en && wr_addr == 7'(`EQR_A_PRESET0 + p)) begin
        preset_ff[p] <= wr_data;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (shift_ff[6:0])
      `EQR_A_ROUTE: rd_data = route_reg_ff;
      `EQR_A_EQ: rd_data = eq_reg_ff;
      `EQR_A_MANUAL: rd_data = manual_ff;
      `EQR_A_LOWRATE: rd_data = lowrate_ff;
      `EQR_A_OUT: rd_data = out_reg_ff;
      `EQR_A_STATUS: rd_data = {strap_lvl[`EQR_PIN_OUTFN], route_lvl, ctl_ff.rate_video,
                                ad_st_ff == AD_DONE, ctl_ff.sel_trace, ctl_ff.power_save};
      `EQR_A_BOOST: rd_data = ctl_ff.trace_boost;
      default: begin
        if (shift_ff[6:4] == 3'(`EQR_A_PRESET0 >> 4)) begin
          rd_data = preset_ff[shift_ff[3:0]];
        end
      end
    endcase
  end

  function automatic eqr_route_t route_of(input eqr_level_t l);
    case (l)
      LVL_H: route_of = '{sel_trace: 1'b0, first_output_en: 1'b1, second_output_en: 1'b1, rate_video: 1'b1};
      LVL_F: route_of = '{sel_trace: 1'b0, first_output_en: 1'b1, second_output_en: 1'b0, rate_video: 1'b1};
      LVL_R: route_of = '{sel_trace: 1'b1, first_output_en: 1'b0, second_output_en: 1'b1, rate_video: 1'b0};
      default: route_of = '{sel_trace: 1'b1, first_output_en: 1'b1, second_output_en: 1'b1, rate_video: 1'b0};
    endcase
  endfunction

  // override bit wins only while set
  assign route_lvl = route_reg_ff[`EQR_B_ROUTE_OVR] ? eqr_level_t'(route_reg_ff[1:0])
                                                    : strap_lvl[`EQR_PIN_ROUTE];
  assign rt = route_of(route_lvl);
  assign cd_sel = rt.sel_trace ? cd_trace_s : cd_cable_s;
  assign trace_auto = eq_reg_ff[`EQR_B_TMODE_OVR] ? !eq_reg_ff[`EQR_B_TMANUAL] : 1'b1;
  // low rates never scan; fixed code applies instead
  assign adapt_run = rt.sel_trace && cd_sel && trace_auto && !rate_low_s
                     && !nxt_ctl.eq_bypass;

  // trace preset scan, best eye metric wins, earliest preset on a tie
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ad_st_ff <= AD_IDLE;
      idx_ff <= 4'h0;
      best_idx_ff <= 4'h0;
      best_score_ff <= 8'h00;
      wait_ff <= 8'h00;
    end else if (ce) begin
      if (!adapt_run) begin
        ad_st_ff <= AD_IDLE;
      end else begin
        case (ad_st_ff)
          AD_IDLE: begin
            idx_ff <= 4'h0;
            best_idx_ff <= 4'h0;
            best_score_ff <= 8'h00;
            ad_st_ff <= AD_LOAD;
          end
          AD_LOAD: begin
            wait_ff <= 8'(`EQR_SETTLE_CYC - 1);
            ad_st_ff <= AD_SETTLE;
          end
          AD_SETTLE: begin
            if (wait_ff == 8'h00) begin
              ad_st_ff <= AD_SCORE;
            end else begin
              wait_ff <= 8'(wait_ff - 8'h01);
            end
          end
          AD_SCORE: begin
            if (idx_ff == 4'h0 || eye_metric > best_score_ff) begin
              best_score_ff <= eye_metric;
              best_idx_ff <= idx_ff;
            end
            if (idx_ff == 4'(`EQR_NPRESET - 1)) begin
              ad_st_ff <= AD_DONE;
            end else begin
              idx_ff <= 4'(idx_ff + 4'h1);
              ad_st_ff <= AD_LOAD;
            end
          end
          AD_DONE: ad_st_ff <= AD_DONE;
          default: ad_st_ff <= AD_IDLE;
        endcase
      end
    end
  end
  assign adapt_boost = (ad_st_ff == AD_DONE) ? preset_ff[best_idx_ff] : preset_ff[idx_ff];

  always_comb begin
    nxt_ctl = '0;
    nxt_ctl.sel_trace = rt.sel_trace;
    nxt_ctl.first_output_en = rt.first_output_en;
    nxt_ctl.second_output_en = rt.second_output_en;
    nxt_ctl.rate_video = route_reg_ff[`EQR_B_RATE_OVR] ? !route_reg_ff[`EQR_B_RATE_ETH]
                                                       : rt.rate_video;
    nxt_ctl.power_save = !cd_sel;
    if (eq_reg_ff[`EQR_B_BYP_OVR]) begin
      nxt_ctl.eq_bypass = eq_reg_ff[`EQR_B_BYP];
    end else begin
      nxt_ctl.eq_bypass = strap_lvl[`EQR_PIN_OUTFN] == LVL_H;
    end
    if (out_reg_ff[`EQR_B_OUT_OVR]) begin
      nxt_ctl.cdr_bypass = out_reg_ff[`EQR_B_CDR_BYP];
      nxt_ctl.first_output_clk = out_reg_ff[`EQR_B_FIRST_OUTPUT_CLK];
      nxt_ctl.second_output_clk = out_reg_ff[`EQR_B_SECOND_OUTPUT_CLK];
    end else begin
      nxt_ctl.cdr_bypass = strap_lvl[`EQR_PIN_OUTFN] inside {LVL_H, LVL_L};
      nxt_ctl.second_output_clk = strap_lvl[`EQR_PIN_OUTFN] == LVL_R;
    end
    // in power save neither equalizer draws current
    nxt_ctl.cable_eq_pwr = !rt.sel_trace && cd_sel && !nxt_ctl.eq_bypass;
    nxt_ctl.trace_eq_pwr = rt.sel_trace && cd_sel && !nxt_ctl.eq_bypass;
    nxt_ctl.cable_adapt_en = nxt_ctl.cable_eq_pwr;
    nxt_ctl.splitter_6db = !rt.sel_trace && eq_reg_ff[`EQR_B_SPLIT];
    if (rate_low_s) begin
      nxt_ctl.trace_boost = lowrate_ff;
    end else if (!trace_auto) begin
      nxt_ctl.trace_boost = manual_ff;
    end else begin
      nxt_ctl.trace_boost = adapt_boost;
    end
    // carrier return re-arms the recovery loop without a register write
    nxt_ctl.cdr_reset = (cd_sel && !cd_prev_ff) || eq_reg_ff[`EQR_B_CDR_RST];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cd_prev_ff <= 1'b0;
      ctl_ff <= '{power_save: 1'b1, default: '0};
    end else if (ce) begin
      cd_prev_ff <= cd_sel;
      ctl_ff <= nxt_ctl;
    end
  end
  assign ctl = ctl_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_one_eq_pwr: assert property (!(ctl.cable_eq_pwr && ctl.trace_eq_pwr))
    else $error("both equalizers powered");
  a_psave_carrier: assert property (ce && !cd_sel |=> ctl.power_save
    && !ctl.cable_eq_pwr && !ctl.trace_eq_pwr)
    else $error("power save missed on carrier loss");
  a_normal_carrier: assert property (ce && cd_sel |=> !ctl.power_save)
    else $error("power save while carrier present");
  a_split_cable_only: assert property (ctl.splitter_6db |-> !ctl.sel_trace)
    else $error("splitter mode on trace input");
  a_lowrate_boost: assert property (ce && rate_low_s
    |=> ctl.trace_boost == $past(lowrate_ff))
    else $error("low rate boost not fixed");
  a_strap_high_route: assert property (ce && !route_reg_ff[`EQR_B_ROUTE_OVR]
    && !route_reg_ff[`EQR_B_RATE_OVR] && strap_lvl[`EQR_PIN_ROUTE] == LVL_H
    |=> !ctl.sel_trace && ctl.first_output_en && ctl.second_output_en && ctl.rate_video)
    else $error("high strap routing wrong");
  a_strap_rlow_route: assert property (ce && !route_reg_ff[`EQR_B_ROUTE_OVR]
    && !route_reg_ff[`EQR_B_RATE_OVR] && strap_lvl[`EQR_PIN_ROUTE] == LVL_R
    |=> ctl.sel_trace && !ctl.first_output_en && ctl.second_output_en && !ctl.rate_video)
    else $error("resistor-low strap routing wrong");
  a_override_wins: assert property (ce && route_reg_ff[`EQR_B_ROUTE_OVR]
    && route_reg_ff[1:0] == 2'h0 |=> ctl.sel_trace && ctl.first_output_en && ctl.second_output_en)
    else $error("route override ignored");
  a_scan_step: assert property (ce && adapt_run && ad_st_ff == AD_SCORE
    && idx_ff != 4'hf |=> idx_ff == 4'($past(idx_ff) + 4'h1) && ad_st_ff == AD_LOAD)
    else $error("preset scan did not advance");
  a_settle_len: assert property (ce && adapt_run && ad_st_ff == AD_LOAD
    ##1 (ce && adapt_run)[*8] |-> ad_st_ff == AD_SETTLE)
    else $error("settle ended early");
  a_cdr_rearm: assert property (ce && cd_sel && !cd_prev_ff |=> ctl.cdr_reset)
    else $error("no recovery reset on carrier return");
  a_bypass_reg: assert property (ce && eq_reg_ff[`EQR_B_BYP_OVR]
    && eq_reg_ff[`EQR_B_BYP] |=> ctl.eq_bypass && !ctl.cable_eq_pwr && !ctl.trace_eq_pwr)
    else $error("register bypass ignored");

  c_scan_done: cover property (ad_st_ff == AD_SCORE ##1 ad_st_ff == AD_DONE);
  c_psave_exit: cover property (ctl.power_save ##1 !ctl.power_save);
  c_spi_write: cover property (ce && wr_en);
  c_clock_out: cover property (ctl.second_output_clk && ctl.second_output_en);
endmodule
`default_nettype wire

// ==== test/eqr_far_side.sv ====
// far side model: strap dividers, input carriers and eye score source
`timescale 1ns/100ps
`default_nettype none
module eqr_far_side
  import eqr_pkg::*;
(
  input wire logic core_clk,
  input wire eqr_level_t route_lvl,
  input wire eqr_level_t outfn_lvl,
  input wire logic cable_on,
  input wire logic trace_on,
  input wire logic [7:0] boost,
  output logic [2:0] route_cmp,
  output logic [2:0] outfn_cmp,
  output logic cd_cable,
  output logic cd_trace,
  output logic [7:0] eye_metric
);
  logic [7:0] junk_ff;
  // divider voltage seen by comparators at 0.2, 0.5, 0.8 of io supply
  function automatic logic [2:0] thermo(input eqr_level_t l);
    case (l)
      LVL_H: thermo = 3'h7;
      LVL_F: thermo = 3'h3;
      LVL_R: thermo = 3'h1;
      default: thermo = 3'h0;
    endcase
  endfunction
  assign route_cmp = thermo(route_lvl);
  assign outfn_cmp = thermo(outfn_lvl);
  assign cd_cable = cable_on;
  assign cd_trace = trace_on;
  // no trace signal means the score carries noise, not the last value
  always @(posedge core_clk) begin
    junk_ff <= junk_ff + 8'h3b;
    eye_metric <= trace_on ? (boost ^ 8'h5a) : junk_ff;
  end
  initial junk_ff = 8'h11;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import eqr_pkg::*;
;
  logic core_clk, rst, ce, rate_low, spi_ss_n, spi_sck, spi_mosi, cable_on, trace_on;
  logic spi_miso_o, spi_miso_oe_n;
  logic [2:0] route_cmp, outfn_cmp;
  logic cd_cable, cd_trace;
  logic [7:0] eye_metric;
  eqr_level_t route_lvl, outfn_lvl;
  eqr_ctl_t ctl;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h7a6e;
  int cycles = 0;
  logic [7:0] pre [16];
  logic [7:0] q, v, best;
  logic [3:0] er;
  logic sel, seen;
  eqr_mode_ctrl uut (.core_clk(core_clk), .rst(rst), .ce(ce), .route_cmp(route_cmp),
    .outfn_cmp(outfn_cmp), .cd_cable(cd_cable), .cd_trace(cd_trace), .rate_low(rate_low),
    .eye_metric(eye_metric), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n), .ctl(ctl));
  eqr_far_side far (.core_clk(core_clk), .route_lvl(route_lvl), .outfn_lvl(outfn_lvl),
    .cable_on(cable_on), .trace_on(trace_on), .boost(ctl.trace_boost),
    .route_cmp(route_cmp), .outfn_cmp(outfn_cmp), .cd_cable(cd_cable),
    .cd_trace(cd_trace), .eye_metric(eye_metric));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one frame: rw bit, 7-bit address, 8 data bits, sck phases of 5 clocks
  task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic [15:0] f;
    f = {rd, a, d};
    r = 8'h00;
    spi_ss_n = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      tick(5);
      spi_sck = 1'b1;
      if (i < 8) r = {r[6:0], spi_miso_o};
      if (rd && i < 8) chk(spi_miso_oe_n, 1'b0);
      tick(5);
      spi_sck = 1'b0;
    end
    tick(5);
    spi_ss_n = 1'b1;
    tick(8);
    if (rd) chk(spi_miso_oe_n, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi(1'b0, a, d, r);
  endtask
  // {sel_trace, first_output_en, second_output_en, rate_video} per routing level
  function automatic logic [3:0] exp_route(input logic [1:0] l);
    case (l)
      2'h3: exp_route = 4'h7;
      2'h2: exp_route = 4'h5;
      2'h1: exp_route = 4'ha;
      default: exp_route = 4'he;
    endcase
  endfunction
  function automatic logic [3:0] rt();
    rt = {ctl.sel_trace, ctl.first_output_en, ctl.second_output_en, ctl.rate_video};
  endfunction
  function automatic logic [2:0] pw();
    pw = {ctl.cable_eq_pwr, ctl.trace_eq_pwr, ctl.power_save};
  endfunction
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    rate_low = 1'b0;
    spi_ss_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    cable_on = 1'b0;
    trace_on = 1'b0;
    route_lvl = LVL_F;
    outfn_lvl = LVL_F;
    tick(10);
    chk(ctl, 24'h2);
    rst = 1'b0;
    // strap routing with carrier present, loss and return
    for (int k = 0; k < 8; k++) begin
      route_lvl = eqr_level_t'(k[1:0]);
      er = exp_route(k[1:0]);
      sel = er[3];
      cable_on = ~sel;
      trace_on = sel;
      tick(8);
      chk(rt(), er);
      chk(pw(), {~sel, sel, 1'b0});
      chk({ctl.cable_adapt_en, ctl.splitter_6db}, {~sel, 1'b0});
      // other input's carrier must not keep normal mode alive
      cable_on = sel ? 1'($random(seed)) : 1'b0;
      trace_on = sel ? 1'b0 : 1'($random(seed));
      tick(6);
      chk(pw(), 3'h1);
      cable_on = ~sel;
      trace_on = sel;
      seen = 1'b0;
      for (int j = 0; j < 8; j++) begin
        tick(1);
        seen = seen | ctl.cdr_reset;
      end
      chk({seen, ctl.power_save}, 2'h2);
    end
    // register override of routing and rate family
    route_lvl = LVL_F;
    cable_on = 1'b1;
    trace_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = 8'hc0 | (8'($random(seed)) & 8'h10) | 8'(k);
      wr(7'h01, v);
      er = exp_route(v[1:0]);
      chk(rt(), {er[3:1], ~v[4]});
    end
    wr(7'h01, 8'h00);
    chk(rt(), 4'h5);
    // rate family changed with live data: software pulses the recovery reset
    wr(7'h02, 8'h20);
    chk(ctl.cdr_reset, 1'b1);
    wr(7'h02, 8'h00);
    chk(ctl.cdr_reset, 1'b0);
    // splitter only through the register port
    wr(7'h02, 8'h01);
    chk(ctl.splitter_6db, 1'b1);
    wr(7'h02, 8'h00);
    // bypass and output content through strap and register
    outfn_lvl = LVL_H;
    tick(8);
    chk({ctl.eq_bypass, ctl.cdr_bypass}, 2'h3);
    outfn_lvl = LVL_L;
    tick(8);
    chk({ctl.eq_bypass, ctl.cdr_bypass, ctl.second_output_clk}, 3'h2);
    outfn_lvl = LVL_F;
    wr(7'h02, 8'h06);
    chk(ctl.eq_bypass, 1'b1);
    wr(7'h02, 8'h02);
    chk(ctl.eq_bypass, 1'b0);
    outfn_lvl = LVL_R;
    tick(8);
    chk({ctl.first_output_clk, ctl.second_output_clk}, 2'h1);
    wr(7'h05, 8'h85);
    chk({ctl.first_output_clk, ctl.second_output_clk, ctl.cdr_bypass}, 3'h5);
    wr(7'h05, 8'h00);
    outfn_lvl = LVL_F;
    wr(7'h02, 8'h00);
    // presets, read back and an unmapped place
    best = 8'h00;
    for (int k = 0; k < 16; k++) begin
      pre[k] = 8'($random(seed));
      if (k == 9) pre[k] = pre[2];
      wr(7'h40 + 7'(k), pre[k]);
      if ((pre[k] ^ 8'h5a) > (pre[best] ^ 8'h5a)) best = 8'(k);
    end
    spi(1'b1, 7'h4f, 8'h00, q);
    chk(q, pre[15]);
    spi(1'b1, 7'h7e, 8'h00, q);
    chk(q, 8'h00);
    // adaptive scan on trace input at 10 GbE
    route_lvl = LVL_L;
    tick(700);
    chk(ctl.trace_boost, pre[best]);
    spi(1'b1, 7'h09, 8'h00, q);
    chk(q, pre[best]);
    // status: outfn float, route hard-low, 10 GbE, scan done, trace, awake
    spi(1'b1, 7'h08, 8'h00, q);
    chk(q, 8'h86);
    rate_low = 1'b1;
    tick(8);
    chk(ctl.trace_boost, 8'h00);
    v = 8'($random(seed));
    wr(7'h04, v);
    chk(ctl.trace_boost, v);
    rate_low = 1'b0;
    v = 8'($random(seed));
    wr(7'h03, v);
    wr(7'h02, 8'h18);
    chk(ctl.trace_boost, v);
    // clock enable low freezes the strap path and the outputs
    ce = 1'b0;
    route_lvl = LVL_H;
    tick(8);
    chk(rt(), 4'he);
    ce = 1'b1;
    tick(8);
    chk(rt(), 4'h7);
    test_done();
  end
endmodule
`default_nettype wire
